// ---- rtl/pmc_map.vh ----
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// Register indices; byte address is four times the index
`define PMC_IDX_PCMD    4'h0
`define PMC_IDX_PMASK   4'h1
`define PMC_IDX_SCMD    4'h2
`define PMC_IDX_SMASK   4'h3
`define PMC_IDX_STS     4'h4
`define PMC_IDX_IMSK    4'h5
`define PMC_IDX_ISR     4'h6
`define PMC_IDX_IRR     4'h7
`define PMC_IDX_LAST    4'h7

`define PMC_AW          6

// Command byte fields
`define PMC_F_INIT      4
`define PMC_F_STAT      3
`define PMC_F_ICW4      0

// Priority command codes, bits 7-5
`define PMC_C_NSEOI     3'h1
`define PMC_C_NOP       3'h2
`define PMC_C_SEOI      3'h3
`define PMC_C_RNSEOI    3'h5
`define PMC_C_SETPRI    3'h6
`define PMC_C_RSEOI     3'h7

// Reset values and the spurious-acknowledge vector
`define PMC_MASK_RST    16'hffff
`define PMC_LOW_RST     6'h3f
`define PMC_SPUR_VEC    4'h7

// Primary level that carries the secondary's requests
`define PMC_CASCADE     3'h2
`define PMC_EDGE_USED   16'hfffb

// Sticky event bits
`define PMC_EV_EOI      0
`define PMC_EV_ACK      1
`define PMC_EV_SPUR     2
`define PMC_EV_RSVD     3

`define PMC_RESP_OKAY   2'h0
`define PMC_RESP_SLVERR 2'h2

`endif

// ---- rtl/pmc_resolver.v ----
`timescale 1ns/10ps
`default_nettype none

module pmc_resolver (
  input  wire [7:0] req,
  input  wire [7:0] in_service_register,
  input  wire [2:0] low,
  output reg        req_valid,
  output reg  [2:0] req_lvl,
  output reg        top_valid,
  output reg  [2:0] top_lvl
);

  reg [2:0] lvl;
  reg [3:0] req_rank;
  reg [3:0] top_rank;
  integer   k;

  // Rank 0 is the level just above the lowest one
  always @* begin
    lvl       = 3'h0;
    req_rank  = 4'h8;
    top_rank  = 4'h8;
    req_lvl   = 3'h0;
    top_lvl   = 3'h0;
    for (k = 7; k >= 0; k = k - 1) begin
      lvl = low + 3'h1 + k[2:0];
      if (req[lvl]) begin
        req_rank = k[3:0];
        req_lvl  = lvl;
      end
      if (in_service_register[lvl]) begin
        top_rank = k[3:0];
        top_lvl  = lvl;
      end
    end
    top_valid = (top_rank != 4'h8);
    // Equal or lower priority than an in-service level is held off
    req_valid = (req_rank < top_rank);
  end

endmodule // pmc_resolver

`default_nettype wire

// ---- rtl/pmc_top.v ----
// What this block does
// - Mask location reads back the mask
// - Mask bit one blocks its request line
// - Bit n is level n, or n+8
// - Primary level two mask blocks secondary
// - Priority command recognised when bits 4-3 zero
// - Decode end-of-service, no-op, reserved codes
// - Specific end-of-service uses low three bits
// - Codes 101, 111 rotate with end-of-service
// - Code 110 sets priority for named level
// - Level field used only with select flag
// - Level field is plain binary level number
// - Bit 4 starts init; 01 is status command
// - In-service holds acknowledged, unfinished levels
// - In-service blocks equal and lower priority
`include "pmc_map.vh"
`timescale 1ns/10ps
`default_nettype none

module pmc_top (
  input  wire                MCLK,
  input  wire                RST,
  input  wire [`PMC_AW-1:0]  S_AXI_AWADDR,
  input  wire                S_AXI_AWVALID,
  output reg                 S_AXI_AWREADY,
  input  wire [31:0]         S_AXI_WDATA,
  input  wire [3:0]          S_AXI_WSTRB,
  input  wire                S_AXI_WVALID,
  output reg                 S_AXI_WREADY,
  output reg  [1:0]          S_AXI_BRESP,
  output reg                 S_AXI_BVALID,
  input  wire                S_AXI_BREADY,
  input  wire [`PMC_AW-1:0]  S_AXI_ARADDR,
  input  wire                S_AXI_ARVALID,
  output reg                 S_AXI_ARREADY,
  output reg  [31:0]         S_AXI_RDATA,
  output reg  [1:0]          S_AXI_RRESP,
  output reg                 S_AXI_RVALID,
  input  wire                S_AXI_RREADY,
  input  wire [15:0]         IRQ_IN,
  input  wire                INTA_IN,
  output reg                 INT_OUT,
  output reg  [3:0]          VECTOR,
  output reg                 IRQ
);

  function [3:0] reg_idx;
    input [`PMC_AW-1:0] a;
    reg_idx = a[5:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [`PMC_AW-1:0] awaddr_q;
  reg [7:0]         wbyte_q;
  reg               wlane_q;
  reg               aw_full_q;
  reg               w_full_q;
  reg [15:0]        mask_q, mask_d;
  reg [15:0]        isr_q, isr_d;
  reg [15:0]        irr_q, irr_d;
  reg [5:0]         low_q, low_d;
  reg [3:0]         init_q, init_d;
  reg [15:0]        scmd_q, scmd_d;
  reg [3:0]         sts_q, sts_d;
  reg [3:0]         imsk_q, imsk_d;
  reg [3:0]         vec_d;
  reg [15:0]        irq_s1_q, irq_s2_q, irq_s3_q;
  reg               inta_s1_q, inta_s2_q, inta_s3_q;
  reg [15:0]        isr_set, irr_clr;
  reg [3:0]         ev;
  reg [31:0]        rd_mux;
  reg [2:0]         lv;
  reg [2:0]         top;
  integer           c;

  wire        p_val, s_val, p_topv, s_topv;
  wire [2:0]  p_lvl, s_lvl, p_top, s_top;
  wire [3:0]  widx    = reg_idx(awaddr_q);
  wire [3:0]  ridx    = reg_idx(S_AXI_ARADDR);
  wire        wr_go   = aw_full_q & w_full_q & ~S_AXI_BVALID;
  wire        do_wr   = wr_go & wlane_q;
  wire [7:0]  wd      = wbyte_q;
  wire [1:0]  hit     = {do_wr & (widx[3:1] == 3'h1), do_wr & (widx[3:1] == 3'h0)};
  wire        ack_evt = inta_s2_q & ~inta_s3_q;
  wire [5:0]  tops    = {s_top, p_top};
  wire [1:0]  topv    = {s_topv, p_topv};
  wire [15:0] active  = irr_q & ~mask_q;

  ////////////////////////////////////////////////////////////////////////////
  // Secondary output enters primary level two, so its mask gates it
  pmc_resolver u_sec (
    .req       (active[15:8]),
    .in_service_register       (isr_q[15:8]),
    .low       (low_q[5:3]),
    .req_valid (s_val),
    .req_lvl   (s_lvl),
    .top_valid (s_topv),
    .top_lvl   (s_top)
  );

  pmc_resolver u_pri (
    .req       ({active[7:3], s_val & ~mask_q[2], active[1:0]}),
    .in_service_register       (isr_q[7:0]),
    .low       (low_q[2:0]),
    .req_valid (p_val),
    .req_lvl   (p_lvl),
    .top_valid (p_topv),
    .top_lvl   (p_top)
  );

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    mask_d  = mask_q;
    isr_d   = isr_q;
    low_d   = low_q;
    init_d  = init_q;
    scmd_d  = scmd_q;
    vec_d   = VECTOR;
    isr_set = 16'h0000;
    irr_clr = 16'h0000;
    ev      = 4'h0;
    lv      = wd[2:0];
    top     = 3'h0;
    if (ack_evt) begin
      if (p_val) begin
        ev[`PMC_EV_ACK]     = 1'b1;
        isr_set[{1'b0, p_lvl}] = 1'b1;
        irr_clr[{1'b0, p_lvl}] = 1'b1;
        if (p_lvl == `PMC_CASCADE) begin
          if (s_val) begin
            isr_set[{1'b1, s_lvl}] = 1'b1;
            irr_clr[{1'b1, s_lvl}] = 1'b1;
            vec_d = {1'b1, s_lvl};
          end else begin
            vec_d = {1'b1, 3'h7};
          end
        end else begin
          vec_d = {1'b0, p_lvl};
        end
      end else begin
        ev[`PMC_EV_SPUR] = 1'b1;
        vec_d = `PMC_SPUR_VEC;
      end
    end
    for (c = 0; c < 2; c = c + 1) begin
      top = tops[c*3 +: 3];
      if (hit[c] && !widx[0]) begin
        if (wd[`PMC_F_INIT]) begin
          init_d[c*2 +: 2]  = wd[`PMC_F_ICW4] ? 2'h3 : 2'h2;
          isr_d[c*8 +: 8]   = 8'h00;
          low_d[c*3 +: 3]   = 3'h7;
        end else if (wd[`PMC_F_STAT]) begin
          scmd_d[c*8 +: 8]  = wd;
        end else begin
          case (wd[7:5])
            `PMC_C_NSEOI: begin
              if (topv[c]) isr_d[c*8 + top] = 1'b0;
              ev[`PMC_EV_EOI] = 1'b1;
            end
            `PMC_C_SEOI: begin
              isr_d[c*8 + lv] = 1'b0;
              ev[`PMC_EV_EOI] = 1'b1;
            end
            `PMC_C_RNSEOI: begin
              if (topv[c]) begin
                isr_d[c*8 + top] = 1'b0;
                low_d[c*3 +: 3]  = top;
              end
              ev[`PMC_EV_EOI] = 1'b1;
            end
            `PMC_C_RSEOI: begin
              isr_d[c*8 + lv] = 1'b0;
              low_d[c*3 +: 3] = lv;
              ev[`PMC_EV_EOI] = 1'b1;
            end
            `PMC_C_SETPRI: begin
              low_d[c*3 +: 3] = lv;
            end
            `PMC_C_NOP: begin
            end
            default: begin
              ev[`PMC_EV_RSVD] = 1'b1;
            end
          endcase
        end
      end else if (hit[c] && widx[0]) begin
        // Odd writes feed init words until the sequence is done
        if (init_q[c*2 +: 2] != 2'h0) begin
          init_d[c*2 +: 2] = init_q[c*2 +: 2] - 2'h1;
        end else begin
          mask_d[c*8 +: 8] = wd;
        end
      end
    end
    // A new acknowledge wins over a same-cycle end-of-service
    isr_d = isr_d | isr_set;
    irr_d = (irr_q & ~irr_clr) | (irq_s2_q & ~irq_s3_q & `PMC_EDGE_USED);
  end

  always @* begin
    imsk_d = imsk_q;
    sts_d  = sts_q;
    if (do_wr && widx == `PMC_IDX_IMSK) imsk_d = wd[3:0];
    if (do_wr && widx == `PMC_IDX_STS) sts_d = sts_q & ~wd[3:0];
    sts_d = sts_d | ev;
  end

  always @* begin
    case (ridx)
      `PMC_IDX_PMASK: rd_mux = {24'h000000, mask_q[7:0]};
      `PMC_IDX_SMASK: rd_mux = {24'h000000, mask_q[15:8]};
      `PMC_IDX_STS:   rd_mux = {28'h0000000, sts_q};
      `PMC_IDX_IMSK:  rd_mux = {28'h0000000, imsk_q};
      `PMC_IDX_ISR:   rd_mux = {16'h0000, isr_q};
      `PMC_IDX_IRR:   rd_mux = {16'h0000, irr_q};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers; stage three only serves edge detection
  always @(posedge MCLK) begin
    if (RST) begin
      irq_s1_q  <= 16'h0000;
      irq_s2_q  <= 16'h0000;
      irq_s3_q  <= 16'h0000;
      inta_s1_q <= 1'b0;
      inta_s2_q <= 1'b0;
      inta_s3_q <= 1'b0;
    end else begin
      irq_s1_q  <= IRQ_IN;
      irq_s2_q  <= irq_s1_q;
      irq_s3_q  <= irq_s2_q;
      inta_s1_q <= INTA_IN;
      inta_s2_q <= inta_s1_q;
      inta_s3_q <= inta_s2_q;
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      mask_q  <= `PMC_MASK_RST;
      isr_q   <= 16'h0000;
      irr_q   <= 16'h0000;
      low_q   <= `PMC_LOW_RST;
      init_q  <= 4'h0;
      scmd_q  <= 16'h0000;
      sts_q   <= 4'h0;
      imsk_q  <= 4'h0;
      VECTOR  <= 4'h0;
      INT_OUT <= 1'b0;
      IRQ     <= 1'b0;
    end else begin
      mask_q  <= mask_d;
      isr_q   <= isr_d;
      irr_q   <= irr_d;
      low_q   <= low_d;
      init_q  <= init_d;
      scmd_q  <= scmd_d;
      sts_q   <= sts_d;
      imsk_q  <= imsk_d;
      VECTOR  <= vec_d;
      INT_OUT <= p_val;
      IRQ     <= |(sts_d & imsk_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and data are held independently; one write in flight
  always @(posedge MCLK) begin
    if (RST) begin
      awaddr_q      <= {`PMC_AW{1'b0}};
      wbyte_q       <= 8'h00;
      wlane_q       <= 1'b0;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `PMC_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        awaddr_q      <= S_AXI_AWADDR;
        aw_full_q     <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wbyte_q      <= S_AXI_WDATA[7:0];
        wlane_q      <= S_AXI_WSTRB[0];
        w_full_q     <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (widx > `PMC_IDX_LAST) ? `PMC_RESP_SLVERR : `PMC_RESP_OKAY;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `PMC_RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_mux;
        S_AXI_RRESP   <= (ridx > `PMC_IDX_LAST) ? `PMC_RESP_SLVERR : `PMC_RESP_OKAY;
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

endmodule // pmc_top

`default_nettype wire

// ---- bench/pmc_top_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmc_top_sva (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        INT_OUT,
  input wire logic        IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // Both channels land in holding flops first, so the answer trails by two edges
  a_b_follows: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write not answered");
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
    && $stable(S_AXI_BRESP)) else $error("write answer dropped");
  a_b_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while busy");
  a_b_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID
    && S_AXI_AWREADY && S_AXI_WREADY) else $error("write not released");
  a_r_follows: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID
    && !S_AXI_ARREADY) else $error("read not answered");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
    && $stable(S_AXI_RDATA)) else $error("read data changed");
  a_r_width: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0)
    else $error("read data too wide");
  a_reset_quiet: assert property ($past(RST) |-> !INT_OUT && !IRQ
    && !S_AXI_BVALID && !S_AXI_RVALID) else $error("outputs busy after reset");
  ////////////////////////////////////////
  c_int: cover property ($rose(INT_OUT));
  c_irq: cover property ($rose(IRQ));
  c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule // pmc_top_sva
bind pmc_top pmc_top_sva pmc_top_sva_i (.*);
`default_nettype wire

// ---- bench/pmc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmc_host (
  input  wire logic        MCLK,
  output logic [5:0]       S_AXI_AWADDR,
  output logic             S_AXI_AWVALID,
  input  wire logic        S_AXI_AWREADY,
  output logic [31:0]      S_AXI_WDATA,
  output logic [3:0]       S_AXI_WSTRB,
  output logic             S_AXI_WVALID,
  input  wire logic        S_AXI_WREADY,
  input  wire logic [1:0]  S_AXI_BRESP,
  input  wire logic        S_AXI_BVALID,
  output logic             S_AXI_BREADY,
  output logic [5:0]       S_AXI_ARADDR,
  output logic             S_AXI_ARVALID,
  input  wire logic        S_AXI_ARREADY,
  input  wire logic [31:0] S_AXI_RDATA,
  input  wire logic [1:0]  S_AXI_RRESP,
  input  wire logic        S_AXI_RVALID,
  output logic             S_AXI_RREADY
);
  initial {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID, S_AXI_BREADY} = 0;
  initial {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = 0;
  initial S_AXI_WSTRB = 4'h1;
  task automatic wr(input logic [3:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic a;
    logic w;
    @(posedge MCLK);
    S_AXI_AWADDR  <= {idx, 2'b00};
    S_AXI_WDATA   <= {24'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    a = 0;
    w = 0;
    while (!(a && w)) begin
      @(posedge MCLK);
      // Released lines show a changed value, never the stale one
      if (!a && S_AXI_AWREADY) begin
        a = 1;
        S_AXI_AWVALID <= 1'b0;
        S_AXI_AWADDR  <= ~S_AXI_AWADDR;
      end
      if (!w && S_AXI_WREADY) begin
        w = 1;
        S_AXI_WVALID <= 1'b0;
        S_AXI_WDATA  <= ~S_AXI_WDATA;
      end
    end
    do @(posedge MCLK); while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge MCLK);
    S_AXI_ARADDR  <= {idx, 2'b00};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    do @(posedge MCLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    S_AXI_ARADDR  <= ~S_AXI_ARADDR;
    do @(posedge MCLK); while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
endmodule // pmc_host
`default_nettype wire

// ---- bench/pmc_mask_and_eoi_commands_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module pic_mask_and_eoi_commands_bench;
  logic             MCLK = 0;
  logic             RST = 1;
  logic             INTA_IN = 0;
  logic [15:0]      IRQ_IN = 0;
  wire logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  wire logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  wire logic        INT_OUT, IRQ;
  wire logic [5:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  wire logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  wire logic [3:0]  S_AXI_WSTRB, VECTOR;
  wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  int               miscompares = 0;
  int               checks_done = 0;
  int               seed = 95;
  int               mask_m [4] = '{0, 255, 0, 255};
  int               init_n [4] = '{0, 0, 0, 0};
  logic [7:0]       idle_cmd [4] = '{8'h00, 8'h80, 8'h40, 8'h6d};
  pmc_top pmc_top_i (.*);
  pmc_host pmc_host_i (.*);
  initial forever #10 MCLK = ~MCLK;
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [1:0] r;
    pmc_host_i.wr(i, d, r);
    chk("bresp", r, i > 7 ? 2 : 0);
    // Mask writes are swallowed while an init sequence is still open
    if (i < 4 && !i[0] && d[4])
      init_n[i + 1] = d[0] ? 3 : 2;
    else if (i < 4 && i[0] && init_n[i] > 0)
      init_n[i]--;
    else if (i == 1 || i == 3)
      mask_m[i] = d;
  endtask
  task automatic rd(input logic [3:0] i, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    pmc_host_i.rd(i, d, r);
    chk("rdata", d[15:0], e);
    chk("rresp", r, i > 7 ? 2 : 0);
  endtask
  // Long enough for the two-flop sync and edge detect to settle
  task automatic pulse(input logic [15:0] v);
    @(posedge MCLK);
    IRQ_IN <= v;
    repeat (4) @(posedge MCLK);
    IRQ_IN <= 16'h0;
    repeat (6) @(posedge MCLK);
  endtask
  task automatic ack(input logic [3:0] v);
    @(posedge MCLK);
    INTA_IN <= 1'b1;
    repeat (4) @(posedge MCLK);
    INTA_IN <= 1'b0;
    repeat (4) @(posedge MCLK);
    chk("vector", VECTOR, v);
  endtask
  task automatic io(input logic e);
    repeat (3) @(posedge MCLK);
    chk("int_out", INT_OUT, e);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    rd(4'h1, 16'h00ff);
    rd(4'h3, 16'h00ff);
    rd(4'h0, 16'h0);
    rd(4'h9, 16'h0);
    wr(4'h9, 8'h00);
    wr(4'h0, 8'h11);
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h04);
    wr(4'h1, 8'h01);
    wr(4'h2, 8'h10);
    wr(4'h3, 8'h08);
    wr(4'h3, 8'h02);
    wr(4'h3, 8'h01);
    rd(4'h3, 16'(mask_m[3]));
    repeat (4) begin
      wr(4'h1, 8'($random(seed)));
      wr(4'h3, 8'($random(seed)));
      rd(4'h1, 16'(mask_m[1]));
      rd(4'h3, 16'(mask_m[3]));
    end
    wr(4'h1, 8'hff);
    wr(4'h3, 8'hff);
    pulse(16'h0020);
    io(1'b0);
    rd(4'h7, 16'h0020);
    wr(4'h1, 8'hdf);
    io(1'b1);
    ack(4'h5);
    rd(4'h6, 16'h0020);
    foreach (idle_cmd[k])
      wr(4'h0, idle_cmd[k]);
    rd(4'h6, 16'h0020);
    wr(4'h1, 8'h9f);
    pulse(16'h0040);
    io(1'b0);
    wr(4'h0, 8'h65);
    rd(4'h6, 16'h0);
    io(1'b1);
    ack(4'h6);
    wr(4'h0, 8'h27);
    rd(4'h6, 16'h0);
    rd(4'h4, 16'h000b);
    wr(4'h5, 8'h00);
    chk("irq", IRQ, 1'b0);
    wr(4'h5, 8'h0f);
    chk("irq", IRQ, 1'b1);
    wr(4'h4, 8'h0f);
    chk("irq", IRQ, 1'b0);
    wr(4'h3, 8'hfb);
    pulse(16'h0400);
    io(1'b0);
    wr(4'h1, 8'h9b);
    io(1'b1);
    ack(4'ha);
    rd(4'h6, 16'h0404);
    wr(4'h2, 8'he2);
    rd(4'h6, 16'h0004);
    wr(4'h0, 8'ha0);
    rd(4'h6, 16'h0);
    // Level 3 would win unless the set-priority took effect
    wr(4'h0, 8'hc4);
    wr(4'h1, 8'hd7);
    pulse(16'h0028);
    ack(4'h5);
    // Level 3 is below in-service level 5, so this acknowledge finds nothing
    ack(4'h7);
    rd(4'h6, 16'h0020);
    rd(4'h4, 16'h0007);
    end_of_test();
  end
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule // pic_mask_and_eoi_commands_bench
`default_nettype wire
